// file: logic/pdm_pkg.sv
// shared constants and carrier types of the pre-driver mode, mask and dead-time control
`default_nettype none

package pdm_pkg;

	// ----------------------------------------
	// command byte layout
	// ----------------------------------------
	localparam int PDM_CMD_W = 8;
	localparam int PDM_OP_LSB = 5;
	localparam int PDM_HALF_BIT = 4;
	localparam logic [2:0] PDM_OP_NULL = 3'h0;
	localparam logic [2:0] PDM_OP_MASK = 3'h1;
	localparam logic [2:0] PDM_OP_MODE = 3'h2;
	localparam logic [2:0] PDM_OP_CLEAR = 3'h3;
	localparam logic [2:0] PDM_OP_DEAD = 3'h4;
	localparam int PDM_MODE_SHUT_BIT = 3;
	localparam int PDM_MODE_FULL_BIT = 1;
	localparam int PDM_MODE_LOCK_BIT = 0;
	localparam int PDM_DEAD_CAL_BIT = 0;

	// ----------------------------------------
	// fault latch bit positions and reset values
	// ----------------------------------------
	localparam int PDM_FLT_OT = 0;
	localparam int PDM_FLT_DESAT = 1;
	localparam int PDM_FLT_VLS = 2;
	localparam int PDM_FLT_OC = 3;
	localparam int PDM_FLT_PHASE = 4;
	localparam int PDM_FLT_FRAME = 5;
	localparam int PDM_FLT_WRERR = 6;
	localparam int PDM_FLT_RESET = 7;
	localparam logic [7:0] PDM_FAULT_RST = 8'h80;
	localparam logic [7:0] PDM_MASK_RST = 8'hFF;
	localparam logic [7:0] PDM_DEAD_RST = 8'hFF;
	localparam logic [7:0] PDM_DEAD_ZERO = 8'h00;

	// ----------------------------------------
	// calibration: pulse width is sixteen dead times
	// ----------------------------------------
	localparam int PDM_CAL_SHIFT = 4;
	localparam int PDM_CAL_CNT_W = 16;

	// ----------------------------------------
	// synchronised pin vector layout
	// ----------------------------------------
	localparam int PDM_PIN_W = 17;
	localparam int PDM_PIN_HS = 0;
	localparam int PDM_PIN_LS = 3;
	localparam int PDM_PIN_CMP = 6;
	localparam int PDM_PIN_DET = 9;
	localparam int PDM_PIN_EN = 13;
	localparam int PDM_PIN_SI = 14;
	localparam int PDM_PIN_SCLK = 15;
	localparam int PDM_PIN_CS = 16;
	localparam logic [16:0] PDM_PIN_RST = 17'h1_0000;

	typedef enum logic [1:0] {
		PDM_CAL_IDLE,
		PDM_CAL_ARMED,
		PDM_CAL_MEASURE
	} pdm_cal_state_t;

	typedef struct packed {
		logic shut_off_dis;
		logic full_on;
		logic lock;
	} pdm_mode_t;

	typedef struct packed {
		logic over_curr;
		logic low_side_supply_uv;
		logic desat;
		logic over_temp_detector;
	} pdm_det_t;

endpackage : pdm_pkg

`default_nettype wire

// file: logic/pdm_phase.sv
// one phase: dead-time interlock, drive outputs and phase error detection
`default_nettype none

module pdm_phase
	import pdm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hs_req,
	input wire logic ls_req,
	input wire logic phase_cmp,
	input wire logic full_on,
	input wire logic force_off,
	input wire logic [7:0] dead_time,
	output logic hs_drv_q,
	output logic ls_drv_q,
	output logic phase_err_q
);

	logic hs_d;
	logic ls_d;
	logic [7:0] dt_cnt_q;
	logic [7:0] blank_q;
	logic turn_off;
	logic turn_on;
	logic err_d;

	// ----------------------------------------
	// drive decision
	// ----------------------------------------
	always_comb begin
		hs_d = 1'b0;
		ls_d = 1'b0;
		if (force_off) begin
			hs_d = 1'b0;
			ls_d = 1'b0;
		end else if (full_on) begin
			hs_d = hs_req;
			ls_d = ls_req;
		end else begin
			// both requested: neither side on, also with zero dead time
			hs_d = hs_req & ~ls_req & (hs_drv_q | (~ls_drv_q & (dt_cnt_q == 8'h00)));
			ls_d = ls_req & ~hs_req & (ls_drv_q | (~hs_drv_q & (dt_cnt_q == 8'h00)));
		end
	end

	assign turn_off = (hs_drv_q & ~hs_d) | (ls_drv_q & ~ls_d);
	assign turn_on = (~hs_drv_q & hs_d) | (~ls_drv_q & ls_d);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hs_drv_q <= 1'b0;
			ls_drv_q <= 1'b0;
		end else begin
			hs_drv_q <= hs_d;
			ls_drv_q <= ls_d;
		end
	end

	// ----------------------------------------
	// dead-time timer, started by any turn-off
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dt_cnt_q <= PDM_DEAD_RST;
		end else if (turn_off) begin
			dt_cnt_q <= dead_time;
		end else if (dt_cnt_q != 8'h00) begin
			dt_cnt_q <= dt_cnt_q - 8'h01;
		end
	end

	// ----------------------------------------
	// blanking after turn-on, then phase check
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			blank_q <= PDM_DEAD_RST;
		end else if (turn_on) begin
			blank_q <= dead_time;
		end else if (blank_q != 8'h00) begin
			blank_q <= blank_q - 8'h01;
		end
	end

	always_comb begin
		err_d = 1'b0;
		if (!full_on && !turn_on && blank_q == 8'h00) begin
			err_d = (hs_drv_q & ~ls_drv_q & ~phase_cmp) | (ls_drv_q & ~hs_drv_q & phase_cmp);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_err_q <= 1'b0;
		end else begin
			phase_err_q <= err_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_no_shoot_through: assert property (!full_on |=> !(hs_drv_q && ls_drv_q))
		else $error("both drivers of a phase on outside both-sides-on mode");
	a_dead_load: assert property ($fell(hs_drv_q) |-> dt_cnt_q == $past(dead_time))
		else $error("dead-time timer not loaded at turn-off");
	a_dead_gap: assert property ($rose(ls_drv_q) && !$past(full_on) |-> $past(dt_cnt_q) == 8'h00)
		else $error("low side turned on before dead time expired");
	a_force_off: assert property (force_off |=> !hs_drv_q && !ls_drv_q)
		else $error("drivers on during forced shutdown");
	a_full_on_blank: assert property (full_on |=> !phase_err_q)
		else $error("phase error raised in both-sides-on mode");

endmodule : pdm_phase

`default_nettype wire

// file: logic/pdm_ctrl.sv
// pre-driver control: command decode, masks, mode, lock, faults and dead-time calibration
//
// Function
// - lower mask nibble enables over-temp, desat, supply undervoltage, overcurrent interrupts.
// - upper mask nibble enables phase, framing, write-after-lock and reset interrupts.
// - phase error is comparator xor drive state, ignored during blanking.
// - both-sides-on mode blanks phase error entirely.
// - reset or disable sets reset-event fault; default mask raises interrupt.
// - opcode 010 is mode: bit3 shutdown, bit1 both-sides-on, bit0 lock.
// - lock is set by command only and cleared only by reset.
// - locked mode, dead-time or mask writes are refused and flag write error.
// - both-sides-on drives outputs straight from synchronised inputs.
// - otherwise dead time applies and one phase never has both drivers on.
// - shutdown bit zero: desat or phase error turns all six drivers off.
// - shutdown bit one: no shutdown, but faults latch and interrupt.
// - lock with other mode bits applies the mode then blocks changes.
// - turn-off starts phase timer; opposite turn-on waits for expiry.
// - calibrate command: count low chip-select cycles, divide by sixteen, store.
// - stored dead time is within plus zero, minus one cycle.
// - zero dead-time command stores zero, no pulse, interlock still applies.
// - reset loads dead time with 255 cycles.
// - serial clock or data edges during calibration pulse flag framing error.
// - fault-clear nibble bits clear latches unless fault still present.
// - interrupt output high while any enabled latched fault remains.
`default_nettype none

module pdm_ctrl
	import pdm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_si,
	input wire logic enable,
	input wire logic [2:0] high_side_input,
	input wire logic [2:0] low_side_input,
	input wire logic [2:0] phase_cmp,
	input wire pdm_det_t det,
	output logic [2:0] hs_drv,
	output logic [2:0] ls_drv,
	output logic irq,
	output logic [7:0] fault_status,
	output pdm_mode_t mode_status,
	output logic [7:0] dead_time,
	output logic cal_overflow
);

	// ----------------------------------------
	// pin synchronisers: three stages, stage two and three must agree
	// ----------------------------------------
	logic [PDM_PIN_W-1:0] pin_raw;
	logic [PDM_PIN_W-1:0] s1_q;
	logic [PDM_PIN_W-1:0] s2_q;
	logic [PDM_PIN_W-1:0] s3_q;
	logic [PDM_PIN_W-1:0] pin_q;
	logic [PDM_PIN_W-1:0] pin_d;
	logic [PDM_PIN_W-1:0] agree;

	assign pin_raw = {spi_cs_n, spi_sclk, spi_si, enable, det, phase_cmp,
		low_side_input, high_side_input};
	assign agree = ~(s2_q ^ s3_q);
	assign pin_d = (pin_q & ~agree) | (s3_q & agree);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_q <= PDM_PIN_RST;
			s2_q <= PDM_PIN_RST;
			s3_q <= PDM_PIN_RST;
			pin_q <= PDM_PIN_RST;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic serial_toggle;
	logic en_f;
	pdm_det_t det_f;

	assign cs_fall = pin_q[PDM_PIN_CS] & ~pin_d[PDM_PIN_CS];
	assign cs_rise = ~pin_q[PDM_PIN_CS] & pin_d[PDM_PIN_CS];
	assign sclk_rise = ~pin_q[PDM_PIN_SCLK] & pin_d[PDM_PIN_SCLK];
	assign serial_toggle = (pin_q[PDM_PIN_SCLK] ^ pin_d[PDM_PIN_SCLK])
		| (pin_q[PDM_PIN_SI] ^ pin_d[PDM_PIN_SI]);
	assign en_f = pin_q[PDM_PIN_EN];
	assign det_f = pin_q[PDM_PIN_DET +: 4];

	// ----------------------------------------
	// serial receiver: keeps the last eight bits, counts bits mod eight
	// ----------------------------------------
	pdm_cal_state_t cal_q;
	logic [PDM_CMD_W-1:0] sh_q;
	logic [2:0] bits_q;
	logic any_bits_q;
	logic measuring;

	assign measuring = (cal_q == PDM_CAL_MEASURE);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sh_q <= 8'h00;
			bits_q <= 3'h0;
			any_bits_q <= 1'b0;
		end else if (cs_fall) begin
			bits_q <= 3'h0;
			any_bits_q <= 1'b0;
		end else if (sclk_rise && !pin_q[PDM_PIN_CS] && !measuring) begin
			sh_q <= {sh_q[PDM_CMD_W-2:0], pin_q[PDM_PIN_SI]};
			bits_q <= bits_q + 3'h1;
			any_bits_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic frame_end;
	logic cmd_take;
	logic frame_bad;
	logic [2:0] opcode;
	logic is_mask;
	logic is_mode;
	logic is_clear;
	logic is_dead;
	logic is_illegal;
	logic locked_write;
	logic write_ok;
	pdm_mode_t mode_q;

	assign frame_end = cs_rise && !measuring;
	assign cmd_take = frame_end && any_bits_q && (bits_q == 3'h0);
	assign frame_bad = frame_end && !(any_bits_q && (bits_q == 3'h0));
	assign opcode = sh_q[PDM_CMD_W-1:PDM_OP_LSB];
	assign is_mask = cmd_take && (opcode == PDM_OP_MASK);
	assign is_mode = cmd_take && (opcode == PDM_OP_MODE);
	assign is_clear = cmd_take && (opcode == PDM_OP_CLEAR);
	assign is_dead = cmd_take && (opcode == PDM_OP_DEAD);
	assign is_illegal = cmd_take && (opcode > PDM_OP_DEAD);
	assign locked_write = (is_mask || is_mode || is_dead) && mode_q.lock;
	assign write_ok = !mode_q.lock;

	// ----------------------------------------
	// mode register; lock only ever sets
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_q <= '0;
		end else if (is_mode && write_ok) begin
			// requested mode and lock land together, later writes then refused
			mode_q.shut_off_dis <= sh_q[PDM_MODE_SHUT_BIT];
			mode_q.full_on <= sh_q[PDM_MODE_FULL_BIT];
			mode_q.lock <= sh_q[PDM_MODE_LOCK_BIT];
		end
	end

	// ----------------------------------------
	// interrupt enable masks
	// ----------------------------------------
	logic [7:0] mask_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mask_q <= PDM_MASK_RST;
		end else if (is_mask && write_ok) begin
			if (sh_q[PDM_HALF_BIT]) begin
				mask_q[7:4] <= sh_q[3:0];
			end else begin
				mask_q[3:0] <= sh_q[3:0];
			end
		end
	end

	// ----------------------------------------
	// dead-time calibration
	// ----------------------------------------
	logic [PDM_CAL_CNT_W-1:0] cal_cnt_q;
	logic [PDM_CAL_CNT_W:0] cal_total;
	logic [PDM_CAL_CNT_W-PDM_CAL_SHIFT:0] cal_quot;
	logic cal_ovf;
	logic [7:0] dead_q;
	logic ovf_q;

	// the rising-edge cycle is the last low cycle of the pulse
	assign cal_total = {1'b0, cal_cnt_q} + {{PDM_CAL_CNT_W{1'b0}}, 1'b1};
	assign cal_quot = cal_total[PDM_CAL_CNT_W:PDM_CAL_SHIFT];
	assign cal_ovf = |cal_quot[PDM_CAL_CNT_W-PDM_CAL_SHIFT:8];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cal_q <= PDM_CAL_IDLE;
		end else begin
			case (cal_q)
				PDM_CAL_IDLE: begin
					if (is_dead && write_ok && sh_q[PDM_DEAD_CAL_BIT]) begin
						cal_q <= PDM_CAL_ARMED;
					end
				end
				PDM_CAL_ARMED: begin
					// the next low pulse is the host's timing pulse
					if (cs_fall) begin
						cal_q <= PDM_CAL_MEASURE;
					end
				end
				PDM_CAL_MEASURE: begin
					if (cs_rise) begin
						cal_q <= PDM_CAL_IDLE;
					end
				end
				default: begin
					cal_q <= PDM_CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cal_cnt_q <= '0;
		end else if (cal_q == PDM_CAL_ARMED) begin
			cal_cnt_q <= '0;
		end else if (measuring && !(&cal_cnt_q)) begin
			cal_cnt_q <= cal_cnt_q + {{(PDM_CAL_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dead_q <= PDM_DEAD_RST;
			ovf_q <= 1'b0;
		end else if (measuring && cs_rise) begin
			dead_q <= cal_ovf ? PDM_DEAD_RST : cal_quot[7:0];
			ovf_q <= cal_ovf;
		end else if (is_dead && write_ok && !sh_q[PDM_DEAD_CAL_BIT]) begin
			dead_q <= PDM_DEAD_ZERO;
			ovf_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// phases
	// ----------------------------------------
	logic [2:0] ph_err;
	logic shut_q;
	logic force_off;

	assign force_off = shut_q | ~en_f;

	for (genvar g = 0; g < 3; g++) begin : g_phase
		pdm_phase u_phase (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.hs_req(pin_q[PDM_PIN_HS + g]),
			.ls_req(pin_q[PDM_PIN_LS + g]),
			.phase_cmp(pin_q[PDM_PIN_CMP + g]),
			.full_on(mode_q.full_on),
			.force_off(force_off),
			.dead_time(dead_q),
			.hs_drv_q(hs_drv[g]),
			.ls_drv_q(ls_drv[g]),
			.phase_err_q(ph_err[g])
		);
	end

	// ----------------------------------------
	// fault latches: a new event wins over a clear in the same cycle
	// ----------------------------------------
	logic [7:0] fault_q;
	logic [7:0] fault_d;
	logic [7:0] fault_set;
	logic [7:0] fault_clr;
	logic irq_q;

	always_comb begin
		fault_set = 8'h00;
		fault_set[PDM_FLT_OT] = det_f.over_temp_detector;
		fault_set[PDM_FLT_DESAT] = det_f.desat | (|ph_err);
		fault_set[PDM_FLT_VLS] = det_f.low_side_supply_uv;
		fault_set[PDM_FLT_OC] = det_f.over_curr;
		fault_set[PDM_FLT_PHASE] = |ph_err;
		fault_set[PDM_FLT_FRAME] = frame_bad | (measuring & serial_toggle);
		fault_set[PDM_FLT_WRERR] = locked_write | is_illegal;
		fault_set[PDM_FLT_RESET] = ~en_f;
		fault_clr = 8'h00;
		if (is_clear) begin
			if (sh_q[PDM_HALF_BIT]) begin
				fault_clr[7:4] = sh_q[3:0];
			end else begin
				fault_clr[3:0] = sh_q[3:0];
			end
		end
		fault_d = (fault_q & ~fault_clr) | fault_set;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fault_q <= PDM_FAULT_RST;
		end else begin
			fault_q <= fault_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			shut_q <= 1'b0;
		end else begin
			// stays until a clear removes both desat and phase latches
			shut_q <= ~mode_q.shut_off_dis
				& (fault_d[PDM_FLT_DESAT] | fault_d[PDM_FLT_PHASE]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(fault_q & mask_q);
		end
	end

	assign irq = irq_q;
	assign fault_status = fault_q;
	assign mode_status = mode_q;
	assign dead_time = dead_q;
	assign cal_overflow = ovf_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_cal_end;
		measuring && cs_rise;
	endsequence

	sequence s_err_shut;
		(|ph_err) && !mode_q.shut_off_dis;
	endsequence

	a_lock_sticky: assert property (mode_q.lock |=> mode_q.lock)
		else $error("lock bit cleared without reset");
	a_locked_write: assert property (locked_write |=> fault_q[PDM_FLT_WRERR] && $stable(mode_q))
		else $error("locked write not refused or not flagged");
	a_reset_event: assert property ($rose(rst_n) |-> fault_q[PDM_FLT_RESET] ##1 irq_q)
		else $error("reset event or its interrupt missing after reset");
	a_cal_store: assert property (s_cal_end ##0 !cal_ovf |=> dead_q == $past(cal_quot[7:0]))
		else $error("calibrated dead time not stored");
	a_cal_ovf: assert property (s_cal_end ##0 cal_ovf |=> dead_q == PDM_DEAD_RST && ovf_q)
		else $error("calibration overflow not saturated");
	a_err_shutdown: assert property (s_err_shut |-> ##2 (hs_drv == 3'h0 && ls_drv == 3'h0))
		else $error("drivers not shut down after phase error");
	a_no_shutdown: assert property (mode_q.shut_off_dis && $past(mode_q.shut_off_dis) |-> !shut_q)
		else $error("shutdown while shutdown is disabled");
	a_irq_follow: assert property ((|(fault_q & mask_q)) [*2] |-> irq_q)
		else $error("interrupt low with enabled latched fault");
	a_cal_frame: assert property (measuring && serial_toggle |=> fault_q[PDM_FLT_FRAME])
		else $error("serial activity during calibration not flagged");

endmodule : pdm_ctrl

`default_nettype wire

// file: tb/pdm_host.sv
// host-side serial command and calibration pulse model
`default_nettype none

module pdm_host (
	output var logic spi_cs_n,
	output var logic spi_sclk,
	output var logic spi_si
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// serial link, 125 ns bit period, idle clock low
	// ----------------------------------------
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_si = 1'b0;
	end

	// sends the top nbits of cmd, msb first
	task automatic send(input logic [7:0] cmd, input int nbits);
		spi_cs_n = 1'b0;
		#62.5;
		for (int i = 7; i > 7 - nbits; i--) begin
			spi_si = cmd[i];
			#62.5;
			spi_sclk = 1'b1;
			#62.5;
			spi_sclk = 1'b0;
		end
		#62.5;
		spi_cs_n = 1'b1;
		// released data line falls to its pull-down
		spi_si = 1'b0;
		#100;
	endtask : send

	// one low pulse of the given length in 10 ns units, clock optionally wiggled
	task automatic cal(input int units, input logic wiggle);
		spi_cs_n = 1'b0;
		for (int i = 0; i < units; i++) begin
			#10;
			if (wiggle && (i % 64 == 0)) begin
				spi_sclk = ~spi_sclk;
			end
		end
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		#100;
	endtask : cal
endmodule : pdm_host

`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the pre-driver mode, mask and dead-time control
`default_nettype none

module tb
	import pdm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk, rst_n, enable, ok, both;
	logic spi_cs_n, spi_sclk, spi_si, irq, cal_overflow;
	logic [2:0] high_side_input, low_side_input, hs_drv, ls_drv;
	logic [2:0] phase_cmp = 3'h0;
	pdm_det_t det;
	pdm_mode_t mode_status;
	logic [7:0] fault_status, dead_time;
	int n_fail, checks, cycles, n;

	pdm_host host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si));

	pdm_ctrl dut (
		.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_si(spi_si), .enable(enable), .high_side_input(high_side_input),
		.low_side_input(low_side_input), .phase_cmp(phase_cmp), .det(det), .hs_drv(hs_drv),
		.ls_drv(ls_drv), .irq(irq), .fault_status(fault_status), .mode_status(mode_status),
		.dead_time(dead_time), .cal_overflow(cal_overflow)
	);

	// ----------------------------------------
	// clock, phase node model, hang guard
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// phase node follows the high side unless a wrong node is commanded
	always @(posedge core_clk) begin
		phase_cmp <= ok ? hs_drv : ~hs_drv;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cmd(input logic [7:0] c, input int nbits);
		host.send(c, nbits);
		@(negedge core_clk);
	endtask : cmd

	task automatic idle(input int k);
		repeat (k) @(negedge core_clk);
	endtask : idle

	task automatic pins(input logic [2:0] hs, input logic [2:0] ls);
		@(posedge core_clk);
		high_side_input <= hs;
		low_side_input <= ls;
	endtask : pins

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset;
		check("faults", fault_status, 8'h80);
		check("mode", {5'h00, mode_status}, 8'h00);
		check("dead", dead_time, 8'hFF);
		check("ovf", {7'h0, cal_overflow}, 8'h00);
		check("irq", {7'h0, irq}, 8'h01);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_masks;
		cmd(8'h7F, 8);
		check("faults", fault_status, 8'h00);
		check("irq", {7'h0, irq}, 8'h00);
		cmd(8'h30, 8);
		cmd(8'hA0, 4);
		check("faults", fault_status, 8'h20);
		check("irq", {7'h0, irq}, 8'h00);
		cmd(8'h32, 8);
		check("irq", {7'h0, irq}, 8'h01);
		cmd(8'h7F, 8);
		cmd(8'h20, 8);
		@(posedge core_clk) det <= 4'h9;
		idle(10);
		check("faults", fault_status, 8'h09);
		check("irq", {7'h0, irq}, 8'h00);
		@(posedge core_clk) det <= 4'h8;
		cmd(8'h29, 8);
		check("irq", {7'h0, irq}, 8'h01);
		cmd(8'h6F, 8);
		check("faults", fault_status, 8'h08);
		@(posedge core_clk) det <= 4'h6;
		idle(10);
		check("faults", fault_status, 8'h0E);
		cmd(8'h6F, 8);
		check("faults", fault_status, 8'h06);
		check("irq", {7'h0, irq}, 8'h00);
		@(posedge core_clk) det <= 4'h0;
		cmd(8'h2F, 8);
		check("irq", {7'h0, irq}, 8'h01);
		cmd(8'h6F, 8);
		cmd(8'h3F, 8);
		@(posedge core_clk) enable <= 1'b0;
		idle(10);
		check("faults", fault_status, 8'h80);
		check("irq", {7'h0, irq}, 8'h01);
		@(posedge core_clk) enable <= 1'b1;
		idle(5);
		cmd(8'h7F, 8);
		check("faults", fault_status, 8'h00);
		$display("test_masks done");
	endtask : test_masks

	task automatic test_cal;
		cmd(8'h81, 8);
		host.cal(16 * 260, 1'b0);
		@(negedge core_clk);
		check("dead", dead_time, 8'hFF);
		check("ovf", {7'h0, cal_overflow}, 8'h01);
		cmd(8'h80, 8);
		check("dead", dead_time, 8'h00);
		cmd(8'h81, 8);
		host.cal(16 * 20, 1'b1);
		@(negedge core_clk);
		check("dead", {7'h0, dead_time === 8'h14 || dead_time === 8'h13}, 8'h01);
		check("ovf", {7'h0, cal_overflow}, 8'h00);
		check("faults", fault_status, 8'h20);
		cmd(8'h7F, 8);
		$display("test_cal done");
	endtask : test_cal

	task automatic test_drive;
		pins(3'h1, 3'h0);
		for (n = 0; n < 400 && hs_drv[0] !== 1'b1; n++) @(negedge core_clk);
		pins(3'h0, 3'h1);
		for (n = 0; n < 400 && hs_drv[0] !== 1'b0; n++) @(negedge core_clk);
		for (n = 0; n < 400 && ls_drv[0] !== 1'b1; n++) @(negedge core_clk);
		check("gap", {7'h0, n >= int'(dead_time) && n <= int'(dead_time) + 8}, 8'h01);
		pins(3'h2, 3'h3);
		both = 1'b0;
		for (n = 0; n < 60; n++) begin
			@(negedge core_clk);
			both |= |(hs_drv & ls_drv);
		end
		check("overlap", {7'h0, both}, 8'h00);
		@(posedge core_clk) ok <= 1'b0;
		idle(60);
		check("phase", {6'h00, fault_status[4], fault_status[1]}, 8'h03);
		check("drv", {2'h0, hs_drv, ls_drv}, 8'h00);
		check("irq", {7'h0, irq}, 8'h01);
		@(posedge core_clk) ok <= 1'b1;
		idle(5);
		cmd(8'h6F, 8);
		cmd(8'h7F, 8);
		idle(60);
		check("faults", fault_status, 8'h00);
		check("ls", {7'h0, ls_drv[0]}, 8'h01);
		cmd(8'h48, 8);
		@(posedge core_clk) ok <= 1'b0;
		idle(60);
		check("phase", {7'h0, fault_status[4]}, 8'h01);
		check("ls", {7'h0, ls_drv[0]}, 8'h01);
		check("irq", {7'h0, irq}, 8'h01);
		@(posedge core_clk) ok <= 1'b1;
		idle(5);
		cmd(8'h6F, 8);
		cmd(8'h7F, 8);
		$display("test_drive done");
	endtask : test_drive

	task automatic test_full;
		cmd(8'h42, 8);
		@(posedge core_clk) ok <= 1'b0;
		pins(3'h6, 3'h7);
		idle(20);
		check("hs", {5'h00, hs_drv}, 8'h06);
		check("ls", {5'h00, ls_drv}, 8'h07);
		idle(300);
		check("faults", fault_status, 8'h00);
		pins(3'h0, 3'h0);
		@(posedge core_clk) ok <= 1'b1;
		idle(10);
		$display("test_full done");
	endtask : test_full

	task automatic test_lock;
		cmd(8'h4B, 8);
		check("mode", {5'h00, mode_status}, 8'h07);
		cmd(8'h40, 8);
		check("mode", {5'h00, mode_status}, 8'h07);
		check("faults", fault_status, 8'h40);
		cmd(8'h7F, 8);
		cmd(8'h80, 8);
		check("dead", {7'h0, dead_time === 8'h14 || dead_time === 8'h13}, 8'h01);
		cmd(8'h7F, 8);
		cmd(8'h30, 8);
		check("faults", fault_status, 8'h40);
		check("irq", {7'h0, irq}, 8'h01);
		cmd(8'h7F, 8);
		check("faults", fault_status, 8'h00);
		cmd(8'hE0, 8);
		check("faults", fault_status, 8'h40);
		$display("test_lock done");
	endtask : test_lock

	initial begin
		rst_n = 1'b0;
		enable = 1'b1;
		ok = 1'b1;
		high_side_input = 3'h0;
		low_side_input = 3'h0;
		det = 4'h0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		idle(3);
		test_reset();
		test_masks();
		test_cal();
		test_drive();
		test_full();
		test_lock();
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
